// ---- verilog/plrt_core.v ----
// power-loss supervision for external-signal coast and decel modes
// How it works
// R1: coast mode: loss input low or relay-open trips
// R2: coast mode loss while running gates inverter
// R3: decel mode: loss input low or relay-open trips
// R4: decel mode loss while running starts ride-through
// R5: ride-through ends coasting on zero, open, permit
// R6: loss sets alarm bit, starts loss timer
// R7: general alarm only when alarm enable set
// R8: loss fault when timer exceeds limit, enabled
// R9: undervoltage fault below minimum when enabled
// R10: relay opens below open, closes above close
// R11: coast mode recovers on input active, relay closed
// R12: decel recovery in ride-through clears alarm, accelerates
// R13: decel recovery after ride-through clears alarm
// R14: coasting permitted drive requests reconnect then accelerate
// R15: run permit from no fault and inputs
// R16: mode code 3 coast, code 4 decel
// R17: loss timer clears when loss ends
`include "plrt_defs.vh"
module plrt_core (
	// clock and reset
	input wire clk,
	input wire rst,
	// configuration
	input wire [`PLRT_MODE_W-1:0] mode,
	input wire alarm_cfg_loss,
	input wire fault_cfg_loss,
	input wire fault_cfg_uv,
	input wire [`PLRT_TIME_W-1:0] loss_time_ms,
	input wire two_wire,
	// bus voltage and thresholds
	input wire [`PLRT_VBUS_W-1:0] vbus,
	input wire [`PLRT_VBUS_W-1:0] v_open,
	input wire [`PLRT_VBUS_W-1:0] v_close,
	input wire [`PLRT_VBUS_W-1:0] v_min,
	input wire [`PLRT_VBUS_W-1:0] v_mem,
	// drive state and pins
	input wire loss_in,
	input wire enable_in,
	input wire not_stop_in,
	input wire run_in,
	input wire running,
	input wire freq_zero,
	input wire fault_clear,
	// outputs
	output reg inverter_off,
	output reg ride_through,
	output reg [`PLRT_VBUS_W-1:0] decel_target,
	output reg relay_closed,
	output reg loss_alarm,
	output reg general_alarm,
	output reg [`PLRT_TIME_W-1:0] loss_timer,
	output reg loss_fault,
	output reg uv_fault,
	output reg reconnect_req,
	output reg accel_req
);

////////////////////////////////////////////////////////////////
reg [2:0] pin_sync;
reg [23:0] tick_cnt;
reg loss_active;

// unsigned level compare, shared by every threshold test
function below_lvl;
	input [`PLRT_VBUS_W-1:0] lvl;
	input [`PLRT_VBUS_W-1:0] lim;
	begin
		below_lvl = (lvl < lim);
	end
endfunction

wire pin_ok = pin_sync[2];
wire coast_mode = (mode == `PLRT_MODE_COAST_IN); // R16
wire decel_mode = (mode == `PLRT_MODE_DECEL_IN); // R16
// any other mode code blocks trips and the undervoltage fault; the relay hysteresis still runs
wire mode_live = coast_mode || decel_mode;
// thresholds come from logic on this clock, so no synchroniser is needed
wire below_open = below_lvl(vbus, v_open);
wire below_min = below_lvl(vbus, v_min);
wire above_close = below_lvl(v_close, vbus);
wire no_fault = !loss_fault && !uv_fault;
wire inputs_ok = enable_in && not_stop_in;
wire run_ok = !two_wire || run_in;
wire permit = no_fault && inputs_ok && run_ok; // R15
wire trip = mode_live && (!pin_ok || below_open); // R1 R3
wire recover = pin_ok && relay_closed; // R11
wire tick = (tick_cnt == `PLRT_TICK_CYC - 1);

// the loss pin is asynchronous; pin_sync[0] feeds only pin_sync[1]
// the extra third stage costs one cycle but filters a marginal settle
always @(posedge clk) begin
	if (rst) begin
		pin_sync <= 3'h0;
	end else begin
		pin_sync <= {pin_sync[1], pin_sync[0], loss_in};
	end
end

////////////////////////////////////////////////////////////////
// millisecond tick for the loss timer
always @(posedge clk) begin
	if (rst || tick) begin
		tick_cnt <= 24'h0;
	end else begin
		tick_cnt <= tick_cnt + 24'h1;
	end
end

////////////////////////////////////////////////////////////////
// relay hysteresis
always @(posedge clk) begin
	if (rst) begin
		relay_closed <= 1'b0;
	end else if (below_open) begin
		relay_closed <= 1'b0; // R10
	end else if (above_close) begin
		relay_closed <= 1'b1; // R10
	end
end

////////////////////////////////////////////////////////////////
// loss timer: whole milliseconds of the current loss, held at full scale
// the tick runs free, so the first counted millisecond may be short
always @(posedge clk) begin
	if (rst) begin
		loss_timer <= 16'h0000;
	end else if (!loss_active) begin
		loss_timer <= 16'h0000; // R17
	end else if (tick && loss_timer != 16'hffff) begin
		loss_timer <= loss_timer + 16'h0001; // R6
	end
end

////////////////////////////////////////////////////////////////
// ride-through regulation target, frozen at the moment of loss
// freezing it keeps the target steady while the bus sags
always @(posedge clk) begin
	if (rst) begin
		decel_target <= 12'h000;
	end else if (!loss_active && trip) begin
		decel_target <= v_mem; // R4
	end
end

////////////////////////////////////////////////////////////////
// loss state, inverter gating and recovery requests
always @(posedge clk) begin
	if (rst) begin
		loss_active <= 1'b0;
		inverter_off <= 1'b0;
		ride_through <= 1'b0;
		loss_alarm <= 1'b0;
		general_alarm <= 1'b0;
		reconnect_req <= 1'b0;
		accel_req <= 1'b0;
	end else begin
		// request pulses last one cycle unless set below
		reconnect_req <= 1'b0;
		accel_req <= 1'b0;
		if (!loss_active) begin
			// a new loss is only taken while no loss is active
			if (trip) begin
				loss_active <= 1'b1;
				loss_alarm <= 1'b1; // R6
				general_alarm <= alarm_cfg_loss; // R7
				if (running && coast_mode) begin
					inverter_off <= 1'b1; // R2
				end
				if (running && decel_mode) begin
					ride_through <= 1'b1; // R4
				end
			end else if (inverter_off && permit) begin
				// reconnect first, then ramp; the pulse pair spans two cycles
				inverter_off <= 1'b0;
				reconnect_req <= 1'b1; // R14
			end
			if (reconnect_req) begin
				accel_req <= 1'b1; // R14
			end
		end else begin
			// ride-through gives up and coasts; recovery below may still clear it
			if (ride_through && (freq_zero || below_open || !permit)) begin
				ride_through <= 1'b0; // R5
				inverter_off <= 1'b1; // R5
			end
			if (recover) begin
				loss_active <= 1'b0; // R11 R13
				loss_alarm <= 1'b0;
				general_alarm <= 1'b0;
				if (ride_through) begin
					ride_through <= 1'b0;
					accel_req <= 1'b1; // R12
				end
			end
		end
	end
end

////////////////////////////////////////////////////////////////
// faults latch until cleared; a new cause wins over the clear
always @(posedge clk) begin
	if (rst) begin
		loss_fault <= 1'b0;
		uv_fault <= 1'b0;
	end else begin
		// set has priority so a standing cause cannot be cleared away
		if (loss_active && fault_cfg_loss && loss_timer > loss_time_ms) begin
			loss_fault <= 1'b1; // R8
		end else if (fault_clear) begin
			loss_fault <= 1'b0;
		end
		if (mode_live && fault_cfg_uv && below_min) begin
			uv_fault <= 1'b1; // R9
		end else if (fault_clear) begin
			uv_fault <= 1'b0;
		end
	end
end

endmodule // plrt_core

// ---- verilog/plrt_defs.vh ----
// constants shared by the power-loss ride-through block
`ifndef PLRT_DEFS_VH
`define PLRT_DEFS_VH
`define PLRT_MODE_W 3
`define PLRT_MODE_COAST_IN 3'h3
`define PLRT_MODE_DECEL_IN 3'h4
`define PLRT_VBUS_W 12
`define PLRT_TIME_W 16
`define PLRT_CLK_HZ 10000000
`define PLRT_TICK_MS 1
`define PLRT_TICK_CYC (`PLRT_CLK_HZ / 1000 * `PLRT_TICK_MS)
`endif

// ---- test/plrt_core_asserts.sv ----
// checker for the power-loss block
module plrt_core_asserts(
	input wire clk, rst, running, loss_alarm, inverter_off, ride_through, relay_closed,
	input wire general_alarm, alarm_cfg_loss, fault_cfg_uv, uv_fault, reconnect_req, accel_req,
	input wire fault_cfg_loss, loss_fault, freq_zero,
	input wire [2:0] mode,
	input wire [11:0] vbus, v_open, v_min,
	input wire [15:0] loss_timer, loss_time_ms
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_trip; $rose(loss_alarm) && $past(running); endsequence
	AST_TRIP: assert property (mode == 4 && vbus < v_open && !loss_alarm |=> loss_alarm) else $error("trip");
	AST_COAST: assert property (mode == 3 ##0 s_trip |-> inverter_off) else $error("coast");
	AST_RIDE: assert property (mode == 4 ##0 s_trip |-> ride_through) else $error("ride");
	AST_GEN: assert property ($rose(loss_alarm) |-> general_alarm == $past(alarm_cfg_loss)) else $error("gen");
	AST_UV: assert property (mode == 4 && fault_cfg_uv && vbus < v_min |=> uv_fault) else $error("uv");
	AST_OPEN: assert property (vbus < v_open |=> !relay_closed) else $error("relay");
	AST_RECON: assert property (reconnect_req |=> accel_req) else $error("accel");
	AST_TCLR: assert property ((!loss_alarm) [*2] |-> loss_timer == 0) else $error("timer");
	AST_LFLT: assert property (loss_alarm && fault_cfg_loss && loss_timer > loss_time_ms |=> loss_fault) else $error("lflt");
	AST_RSTOP: assert property (ride_through && freq_zero |=> !ride_through && inverter_off) else $error("rstop");
endmodule // plrt_core_asserts
bind plrt_core plrt_core_asserts plrt_core_asserts_inst(.*);

// ---- test/plrt_line_mon.sv ----
// line monitor feeding the loss input
module plrt_line_mon(
	input wire clk,
	input wire power_ok,
	output logic loss_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// reports a cycle late, like a real comparator
	initial loss_in = 1;
	always @(posedge clk) loss_in <= power_ok;
endmodule // plrt_line_mon

// ---- test/plrt_core_tb_top.sv ----
// bench for the power-loss block
module plrt_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, power_ok = 1, loss_in, alarm_cfg_loss = 1, fault_cfg_loss = 1, fault_cfg_uv = 1;
	logic two_wire = 0, enable_in = 1, not_stop_in = 1, run_in = 1, running = 1, freq_zero = 0, fault_clear = 0;
	logic [2:0] mode = 0;
	logic [11:0] vbus = 12'h800, v_open = 12'h400, v_close = 12'h600, v_min = 12'h300, v_mem = 12'h7ff;
	logic [15:0] loss_time_ms = 1;
	wire inverter_off, ride_through, relay_closed, loss_alarm, general_alarm, loss_fault, uv_fault;
	wire reconnect_req, accel_req;
	wire [11:0] decel_target;
	wire [15:0] loss_timer;
	int err_count = 0, check_count = 0;
	// mode, then alarm, general alarm, inverter off, ride-through
	logic [6:0] rows [4] = '{7'h00, 7'h50, 7'h3e, 7'h4d};
	plrt_core plrt_core_inst(.*);
	plrt_line_mon plrt_line_mon_inst(.clk, .power_ok, .loss_in);
	initial forever #50 clk = ~clk;
	task chk(input logic [19:0] got, exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %h %h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("mismatches %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task rst6;
		rst <= 1;
		step(6);
		rst <= 0;
	endtask
	initial begin
		foreach (rows[i]) begin
			step(1);
			mode <= rows[i][6:4];
			rst6();
			step(3);
			power_ok <= 0;
			step(8);
			#1 chk({loss_alarm, general_alarm, inverter_off, ride_through}, rows[i][3:0]);
			step(1);
			power_ok <= 1;
			step(8);
		end
		step(1);
		alarm_cfg_loss <= 0;
		rst6();
		step(3);
		vbus <= 12'h200;
		// 2.5 ms of loss against a 1 ms limit
		step(25000);
		#1 chk({loss_alarm, general_alarm, relay_closed, uv_fault, inverter_off, loss_fault}, 6'h27);
		step(1);
		vbus <= 12'h800;
		step(8);
		fault_clear <= 1;
		step(1);
		fault_clear <= 0;
		step(2);
		#1 chk({loss_alarm, loss_fault, uv_fault, loss_timer}, 0);
		// coast recovery walk: alarm clears, then reconnect, then accel
		step(1);
		mode <= 3'h3;
		rst6();
		step(3);
		power_ok <= 0;
		step(8);
		#1 chk(decel_target, v_mem);
		step(1);
		power_ok <= 1;
		step(5);
		#1 chk({loss_alarm, reconnect_req, accel_req, inverter_off}, 4'h1);
		step(1);
		#1 chk({loss_alarm, reconnect_req, accel_req, inverter_off}, 4'h4);
		step(1);
		#1 chk({loss_alarm, reconnect_req, accel_req, inverter_off}, 4'h2);
		// two-wire decel: losing the run input ends ride-through
		step(1);
		mode <= 3'h4;
		two_wire <= 1;
		rst6();
		step(3);
		power_ok <= 0;
		step(8);
		run_in <= 0;
		step(1);
		#1 chk({ride_through, inverter_off}, 2'h1);
		// decel recovery while still riding through
		step(1);
		run_in <= 1;
		power_ok <= 1;
		rst6();
		step(3);
		power_ok <= 0;
		step(8);
		power_ok <= 1;
		step(5);
		#1 chk({ride_through, accel_req, reconnect_req, loss_alarm}, 4'h4);
		test_done();
	end
	initial begin
		#3000000;
		err_count++;
		test_done();
	end
endmodule // plrt_core_tb_top
